// *** rtl/fsb_data_phase_path.sv ***
`timescale 1ns/1ps
module fsb_data_phase_path
    import fsbdp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    // Transmit side: one 64-bit word per sub-phase
    input wire logic txValid,
    output logic txReady,
    input wire logic [fsbdp_pkg::DATA_W-1:0] txData,
    input wire logic invEnable,
    // Receive side
    output logic rxValid,
    output logic [fsbdp_pkg::DATA_W-1:0] rxData,
    // Bus pins, electrically active low apart from busClk and the output enables
    input wire logic busClk,
    input wire logic [fsbdp_pkg::DATA_W-1:0] busData_n_in,
    output logic [fsbdp_pkg::DATA_W-1:0] busData_n_out,
    output logic busData_oe,
    input wire logic [fsbdp_pkg::GRP_N-1:0] groupInv_n_in,
    output logic [fsbdp_pkg::GRP_N-1:0] groupInv_n_out,
    input wire logic [fsbdp_pkg::GRP_N-1:0] strobePos_n_in,
    input wire logic [fsbdp_pkg::GRP_N-1:0] strobeNeg_n_in,
    output logic [fsbdp_pkg::GRP_N-1:0] strobePos_n_out,
    output logic [fsbdp_pkg::GRP_N-1:0] strobeNeg_n_out,
    output logic strobe_oe,
    input wire logic dataValid_n_in,
    output logic dataValid_n_out,
    output logic dataValid_oe,
    input wire logic busBusy_n_in,
    output logic busBusy_n_out,
    output logic busBusy_oe
);
    import fsbdp_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    // Count zero bits of a group as seen electrically
    function automatic logic [4:0] lowCount(input logic [GRP_W-1:0] g);
        logic [4:0] c;
        c = '0;
        for (int i = 0; i < GRP_W; i++)
            c = c + 5'(~g[i]);
        return c;
    endfunction

    // Undo inversion for one 64-bit word
    function automatic logic [DATA_W-1:0] decodeWord(input logic [DATA_W-1:0] pins,
                                                     input logic [GRP_N-1:0] invPins);
        logic [DATA_W-1:0] w;
        w = ~pins;
        for (int g = 0; g < GRP_N; g++)
            if (!invPins[g])
                w[g*GRP_W +: GRP_W] = pins[g*GRP_W +: GRP_W];
        return w;
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [2*GRP_N+3:0] syncA, syncB, syncC;
    logic [DATA_W+GRP_N-1:0] dataA, dataB;
    logic busClkS, busClkPrev, dvS, busyS;
    logic [GRP_N-1:0] spS, snS, spPrev, snPrev;
    assign {busClkS, dvS, busyS, spS, snS} = syncB[2*GRP_N+2:0];
    assign busClkPrev = syncC[2*GRP_N+2];
    assign spPrev = syncC[2*GRP_N-1:GRP_N];
    assign snPrev = syncC[GRP_N-1:0];

    // Two-stage sampling of all bus inputs
    always_ff @(posedge clk_sys)
    begin
        syncA <= {1'b0, busClk, dataValid_n_in, busBusy_n_in, strobePos_n_in, strobeNeg_n_in};
        syncB <= syncA;
        syncC <= syncB;
        dataA <= {groupInv_n_in, busData_n_in};
        dataB <= dataA;
    end

    // ****************************************
    // Receive path
    // ****************************************
    logic rxHit, next_rxValid, busyActive, qualActive, busClkRise;
    logic [DATA_W-1:0] next_rxData;
    assign busyActive = !busyS;
    assign qualActive = !dvS;
    assign busClkRise = busClkS && !busClkPrev;

    // Capture when group 0 strobe falls, transfer qualified
    always_comb
    begin
        rxHit = ((spPrev[0] && !spS[0]) || (snPrev[0] && !snS[0])) && qualActive;
        rxHit = rxHit && !busData_oe;
        next_rxValid = rxHit;
        next_rxData = rxHit ? decodeWord(dataB[DATA_W-1:0], dataB[DATA_W+:GRP_N]) : rxData;
    end

    // Receive registers
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            rxValid <= 1'b0;
            rxData <= '0;
        end
        else
        begin
            rxValid <= next_rxValid;
            rxData <= next_rxData;
        end
    end

    // ****************************************
    // Transmit FIFO
    // ****************************************
    logic fifoValid, fifoReady;
    logic [DATA_W:0] fifoData;

    fsbdp_fifo #(
        .WIDTH(DATA_W + 1),
        .DEPTH(FIFO_DEPTH)
    ) txFifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .inValid(txValid),
        .inReady(txReady),
        .inData({invEnable, txData}),
        .outValid(fifoValid),
        .outReady(fifoReady),
        .outData(fifoData)
    );

    // ****************************************
    // Transmit state machine
    // ****************************************
    fsbdp_state_e state, next_state;
    logic [3:0] subCnt, next_subCnt;
    logic [1:0] subIdx, next_subIdx;
    logic haveWord, next_haveWord;
    logic [DATA_W-1:0] next_busData;
    logic [GRP_N-1:0] next_inv;
    logic next_qual;

    // Sub-phase sequencing, ownership and data encoding
    always_comb
    begin
        next_state = state;
        next_subCnt = subCnt;
        next_subIdx = subIdx;
        next_haveWord = haveWord;
        next_busData = busData_n_out;
        next_inv = groupInv_n_out;
        next_qual = dataValid_n_out;
        fifoReady = 1'b0;
        case (state)
            FSBDP_IDLE:
                if (fifoValid)
                    next_state = FSBDP_WAIT;
            FSBDP_WAIT:
                if (!busyActive && busClkRise)
                begin
                    next_state = FSBDP_DRIVE;
                    next_subCnt = '0;
                    next_subIdx = SUB_RST;
                    next_haveWord = 1'b0;
                end
            FSBDP_DRIVE:
            begin
                next_subCnt = (subCnt == SUB_CYC_MAX) ? 4'h0 : subCnt + 4'h1;
                if (subCnt == 4'h0)
                begin
                    // Start of a sub-phase: take a word or idle it; no word at the first sub-phase idles the whole clock
                    if (subIdx == SUB_RST)
                        next_haveWord = fifoValid;
                    if ((subIdx == SUB_RST) ? fifoValid : haveWord && fifoValid)
                    begin
                        fifoReady = 1'b1;
                        next_qual = 1'b0;
                        for (int g = 0; g < GRP_N; g++)
                        begin
                            logic [GRP_W-1:0] grp;
                            grp = ~fifoData[g*GRP_W +: GRP_W];
                            if (fifoData[DATA_W] && lowCount(grp) > 5'(INV_LIMIT))
                            begin
                                next_busData[g*GRP_W +: GRP_W] = ~grp;
                                next_inv[g] = 1'b0;
                            end
                            else
                            begin
                                next_busData[g*GRP_W +: GRP_W] = grp;
                                next_inv[g] = 1'b1;
                            end
                        end
                    end
                    else
                        next_qual = 1'b1;
                    next_subIdx = subIdx + 2'h1;
                end
                if (subCnt == SUB_CYC_MAX && subIdx == SUB_RST && !fifoValid && !haveWord)
                begin
                    next_state = FSBDP_IDLE;
                    next_qual = 1'b1;
                    // Leave the pins at their idle level once the bus is freed
                    next_busData = '1;
                    next_inv = '1;
                end
            end
            default:
                next_state = FSBDP_IDLE;
        endcase
    end

    // Transmit registers
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            state <= FSBDP_IDLE;
            subCnt <= '0;
            subIdx <= SUB_RST;
            haveWord <= 1'b0;
            busData_n_out <= '1;
            groupInv_n_out <= '1;
            dataValid_n_out <= 1'b1;
        end
        else
        begin
            state <= next_state;
            subCnt <= next_subCnt;
            subIdx <= next_subIdx;
            haveWord <= next_haveWord;
            busData_n_out <= next_busData;
            groupInv_n_out <= next_inv;
            dataValid_n_out <= next_qual;
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    logic driving;
    assign driving = (state == FSBDP_DRIVE);
    assign busData_oe = driving;
    assign strobe_oe = driving;
    assign dataValid_oe = driving;
    assign busBusy_oe = driving;
    assign busBusy_n_out = !driving;
    // Strobes fall mid sub-phase: positive on even, negative on odd
    always_comb
    begin
        strobePos_n_out = {GRP_N{1'b1}};
        strobeNeg_n_out = {GRP_N{1'b1}};
        if (driving && subCnt >= 4'(SUB_CYC / 2) && subIdx[0])
            strobePos_n_out = '0;
        if (driving && subCnt >= 4'(SUB_CYC / 2) && !subIdx[0])
            strobeNeg_n_out = '0;
    end
endmodule

// *** rtl/fsbdp_fifo.sv ***
`timescale 1ns/1ps
module fsbdp_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic doWr, doRd;

    // Full and empty from pointer compare
    assign inReady = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
    assign outValid = wrPtr != rdPtr;
    assign outData = mem[rdPtr[AW-1:0]];
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;

    // Pointer advance
    always_comb
    begin
        next_wrPtr = wrPtr + (AW+1)'(doWr);
        next_rdPtr = rdPtr + (AW+1)'(doRd);
    end

    // Pointer and storage registers
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
        end
        else
        begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
        end
        if (doWr)
            mem[wrPtr[AW-1:0]] <= inData;
    end
endmodule

// *** shared/fsbdp_pkg.sv ***
package fsbdp_pkg;
    // ****************************************
    // Geometry
    // ****************************************
    localparam int DATA_W = 64;
    localparam int GRP_W = 16;
    localparam int GRP_N = 4;
    localparam int SUB_N = 4;
    localparam int FIFO_DEPTH = 16;
    localparam int INV_LIMIT = 8;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int BUS_PERIOD_NS = 125;
    localparam int SUB_PERIOD_NS = BUS_PERIOD_NS / SUB_N;
    localparam int SUB_CYC = SUB_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [3:0] SUB_CYC_MAX = 4'(SUB_CYC - 1);
    localparam logic [1:0] SUB_RST = 2'h0;

    typedef enum logic [1:0] {FSBDP_IDLE, FSBDP_WAIT, FSBDP_DRIVE} fsbdp_state_e;
endpackage

// *** tb/fsbdp_far_agent.sv ***
`timescale 1ns/1ps
module fsbdp_far_agent
    import fsbdp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [fsbdp_pkg::DATA_W-1:0] dataIn_n,
    input wire logic [fsbdp_pkg::GRP_N-1:0] invIn_n,
    input wire logic stbIn_n,
    input wire logic qualIn_n,
    input wire logic dutOe,
    output logic busClk,
    output logic [fsbdp_pkg::DATA_W-1:0] data_n,
    output logic [fsbdp_pkg::GRP_N-1:0] inv_n,
    output logic stbPos_n,
    output logic stbNeg_n,
    output logic qual_n,
    output logic busy_n
);
    import fsbdp_pkg::*;
    logic [DATA_W-1:0] got [$];
    logic [DATA_W-1:0] w;
    logic odd = 1'b0;
    // Free running common clock, off the system clock phase
    initial
    begin
        busClk = 1'b0;
        #1.3;
        forever #62.5 busClk = ~busClk;
    end
    // Released lines float to the termination level
    initial
    begin
        {data_n, inv_n, stbPos_n, stbNeg_n, qual_n, busy_n} = '1;
    end
    // Capture design sub-phases on group 0 strobe falls
    always @(negedge stbIn_n)
    begin
        if (dutOe === 1'b1 && qualIn_n === 1'b0)
        begin
            for (int g = 0; g < GRP_N; g++)
                w[g*GRP_W+:GRP_W] = invIn_n[g] ? ~dataIn_n[g*GRP_W+:GRP_W]
                    : dataIn_n[g*GRP_W+:GRP_W];
            got.push_back(w);
        end
    end
    // One sub-phase; q high marks an idle transfer
    task automatic send(input logic [DATA_W-1:0] v, input logic q);
        @(posedge clk_sys);
        busy_n <= 1'b0;
        qual_n <= q;
        for (int g = 0; g < GRP_N; g++)
        begin
            inv_n[g] <= $countones(v[g*GRP_W+:GRP_W]) <= INV_LIMIT;
            data_n[g*GRP_W+:GRP_W] <= ($countones(v[g*GRP_W+:GRP_W]) > INV_LIMIT)
                ? v[g*GRP_W+:GRP_W] : ~v[g*GRP_W+:GRP_W];
        end
        repeat (3) @(posedge clk_sys);
        if (odd)
            stbPos_n <= 1'b0;
        else
            stbNeg_n <= 1'b0;
        odd = ~odd;
        repeat (3) @(posedge clk_sys);
        stbPos_n <= 1'b1;
        stbNeg_n <= 1'b1;
    endtask
    // Occupy or free the data bus
    task automatic hold_bus();
        @(posedge clk_sys);
        busy_n <= 1'b0;
    endtask
    task automatic release_bus();
        @(posedge clk_sys);
        {data_n, inv_n, qual_n, busy_n} <= '1;
    endtask
endmodule

// *** tb/fsbdp_props.sv ***
`timescale 1ns/1ps
module fsbdp_props
    import fsbdp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic rxValid,
    input wire logic busBusy_n_in,
    input wire logic [fsbdp_pkg::DATA_W-1:0] busData_n_out,
    input wire logic busData_oe,
    input wire logic [fsbdp_pkg::GRP_N-1:0] groupInv_n_out,
    input wire logic [fsbdp_pkg::GRP_N-1:0] strobePos_n_out,
    input wire logic [fsbdp_pkg::GRP_N-1:0] strobeNeg_n_out,
    input wire logic strobe_oe,
    input wire logic dataValid_n_out,
    input wire logic dataValid_oe,
    input wire logic busBusy_n_out,
    input wire logic busBusy_oe
);
    import fsbdp_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // ****************************************
    // Bus ownership
    // ****************************************
    AST_BUSY_HELD: assert property (busData_oe |-> busBusy_oe && !busBusy_n_out)
        else $error("busy not asserted while driving");
    AST_WAIT_FREE: assert property ($rose(busData_oe) |-> $past(busBusy_n_in))
        else $error("drive began while bus still busy");
    AST_QUAL_OWNED: assert property (!dataValid_n_out |-> dataValid_oe && busData_oe)
        else $error("qualifier asserted without driving");
    AST_INV_OWNED: assert property (groupInv_n_out != 4'hF |-> busData_oe)
        else $error("inversion flag without driving");
    AST_INV_COUNT: assert property (busData_oe && !groupInv_n_out[0]
        |-> $countones(busData_n_out[15:0]) > INV_LIMIT)
        else $error("group inverted without low majority");
    // ****************************************
    // Strobes and capture
    // ****************************************
    AST_STB_LEN: assert property ($fell(strobePos_n_out[0])
        |-> !strobePos_n_out[0] [*3] ##1 strobePos_n_out[0])
        else $error("strobe pulse length wrong");
    AST_STB_GROUPS: assert property (strobe_oe |-> strobePos_n_out == {4{strobePos_n_out[0]}}
        && strobeNeg_n_out == {4{strobeNeg_n_out[0]}})
        else $error("group strobes differ");
    AST_STB_ALT: assert property (!strobePos_n_out[0] |-> strobeNeg_n_out[0])
        else $error("both strobes low");
    AST_RX_SINGLE: assert property (rxValid |=> !rxValid)
        else $error("receive pulse too long");
    COV_DRIVE: cover property ($rose(busData_oe));
    COV_RX: cover property (rxValid);
    COV_INV: cover property (busData_oe && !groupInv_n_out[0]);
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    import fsbdp_pkg::*;
    logic clk_sys = 1'b0, reset_n = 1'b0, txValid = 1'b0, invEnable = 1'b0;
    logic [DATA_W-1:0] txData = '0, rxData, busData_n_out, fData;
    logic [GRP_N-1:0] groupInv_n_out, strobePos_n_out, strobeNeg_n_out, fInv;
    logic txReady, rxValid, busClk, busData_oe, strobe_oe, dataValid_n_out, dataValid_oe;
    logic busBusy_n_out, busBusy_oe, fPos, fNeg, fQual, fBusy;
    logic [DATA_W-1:0] rxGot [$];
    int err_count = 0, n_compared = 0, cycles = 0;
    // Wire levels from all drivers
    wire [DATA_W-1:0] dataW = busData_oe ? busData_n_out : fData;
    wire [GRP_N-1:0] invW = busData_oe ? groupInv_n_out : fInv;
    wire [GRP_N-1:0] posW = strobe_oe ? strobePos_n_out : {4{fPos}};
    wire [GRP_N-1:0] negW = strobe_oe ? strobeNeg_n_out : {4{fNeg}};
    wire qualW = dataValid_oe ? dataValid_n_out : fQual;
    wire busyW = (busBusy_oe ? busBusy_n_out : 1'b1) & fBusy;
    wire stbW = posW[0] & negW[0];
    fsb_data_phase_path DUT (
        .clk_sys, .reset_n, .txValid, .txReady, .txData, .invEnable, .rxValid, .rxData,
        .busClk, .busData_n_in(dataW), .busData_n_out, .busData_oe, .groupInv_n_in(invW),
        .groupInv_n_out, .strobePos_n_in(posW), .strobeNeg_n_in(negW), .strobePos_n_out,
        .strobeNeg_n_out, .strobe_oe, .dataValid_n_in(qualW), .dataValid_n_out,
        .dataValid_oe, .busBusy_n_in(busyW), .busBusy_n_out, .busBusy_oe
    );
    fsbdp_far_agent far (
        .clk_sys, .dataIn_n(dataW), .invIn_n(invW), .stbIn_n(stbW), .qualIn_n(qualW),
        .dutOe(busData_oe), .busClk, .data_n(fData), .inv_n(fInv), .stbPos_n(fPos),
        .stbNeg_n(fNeg), .qual_n(fQual), .busy_n(fBusy)
    );
    always #2.5 clk_sys = ~clk_sys;
    // Received words and hang guard
    always @(posedge clk_sys)
    begin
        if (rxValid === 1'b1)
            rxGot.push_back(rxData);
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [63:0] word(input int i);
        return {16'h0F0F ^ 16'(i), 16'hFFFF >> i, 16'h0001 << i, 16'hFFFF >> (15 - i)};
    endfunction
    // Far side sends, one idle sub-phase among them
    task automatic t_rx();
        logic [63:0] w [4];
        w = '{64'h0000_FFFF_00FF_F0F1, 64'h8000_0001_7FFF_FFFE,
              64'h0123_4567_89AB_CDEF, 64'hFFFF_0000_FFFF_0001};
        far.send(w[0], 1'b0);
        far.send(64'h5A5A_5A5A_5A5A_5A5A, 1'b1);
        for (int i = 1; i < 4; i++)
            far.send(w[i], 1'b0);
        far.release_bus();
        repeat (10) @(posedge clk_sys);
        check("rx count", 64'h4, 64'(rxGot.size()));
        for (int i = 0; i < 4; i++)
            check("rx word", w[i], rxGot[i]);
    endtask
    // Fill while far side owns the bus, then drain
    task automatic t_fill();
        far.hold_bus();
        for (int i = 0; i <= FIFO_DEPTH; i++)
        begin
            invEnable <= i[0];
            txValid <= 1'b1;
            txData <= word(i);
            @(negedge clk_sys);
            if (i == FIFO_DEPTH)
                check("full refuses", 64'h0, 64'(txReady));
            @(posedge clk_sys);
        end
        txValid <= 1'b0;
        repeat (20) @(posedge clk_sys);
        check("oe while bus owned", 64'h0, 64'(busData_oe));
        far.release_bus();
        for (int k = 0; k < 3000 && far.got.size() < FIFO_DEPTH; k++)
            @(posedge clk_sys);
        for (int i = 0; i < FIFO_DEPTH; i++)
            check("tx word", word(i), far.got[i]);
        repeat (200) @(posedge clk_sys);
        check("busy released", 64'h1, 64'(busyW));
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_rx();
        t_fill();
        report_and_stop();
    end
endmodule
bind fsb_data_phase_path fsbdp_props chk (
    .clk_sys, .reset_n, .rxValid, .busBusy_n_in, .busData_n_out, .busData_oe,
    .groupInv_n_out, .strobePos_n_out, .strobeNeg_n_out, .strobe_oe, .dataValid_n_out,
    .dataValid_oe, .busBusy_n_out, .busBusy_oe
);
